//--- hdl/pll_cfg.svh
// offsets, field positions, reset values and widths of the clock synthesizer control
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH
`define ADDR_W 4
`define ADDR_STANDBY 4'h0
`define ADDR_OSC_BIAS 4'h1
`define ADDR_REF_HIGH 4'h2
`define ADDR_REF_LOW 4'h3
`define ADDR_FB_HIGH 4'h4
`define ADDR_FB_LOW 4'h5
`define ADDR_PUMP_CTRL 4'h6
`define ADDR_FA_HIGH 4'h7
`define ADDR_FA_LOW 4'h8
`define RST_STANDBY 8'hFF
`define RST_OSC_BIAS 2'h0
`define RST_REF_HIGH 6'h00
`define RST_REF_LOW 8'h38
`define RST_FB_HIGH 5'h00
`define RST_FB_LOW 8'h3C
`define RST_PUMP_CODE 3'h0
`define RST_FA_HIGH 4'h0
`define RST_FA_LOW 8'h04
`define SYNTH_SLEEP_BIT 2
`define OSC_SLEEP_BIT 1
`define OSC_BIAS_LSB 2
`define OSC_BIAS_MSB 3
`define FAST_EN_BIT 6
`define PUMP_CODE_LSB 2
`define PUMP_CODE_MSB 4
`define REF_DIV_W 14
`define FB_DIV_W 13
`define FA_DIV_W 12
`define LEVEL_W 4
`define LEVEL_MAX 4'h8
`define LEVEL_FA_FLOOR 4'h2
`endif

//--- hdl/pll_pkg.sv
// types shared by the clock synthesizer control files
package pll_pkg;
    typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DOWN} pfd_state_type;
    typedef logic [7:0] byte_type;
endpackage

//--- hdl/edge_divider.sv
// programmable divider: one pulse every divValue input edges
`include "pll_cfg.svh"
module edge_divider #(
    parameter int WIDTH = 14
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic enable,
    input wire logic edgeIn,
    input wire logic [WIDTH-1:0] divValue,
    output logic pulse
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    wire terminal = (count_r <= WIDTH'(1));

    // reload from the full divide value on terminal count
    assign count_nxt = !enable ? divValue :
                       (edgeIn ? (terminal ? divValue : count_r - WIDTH'(1)) : count_r);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count_r <= '0;
            pulse <= 1'b0;
        end else begin
            count_r <= count_nxt;
            pulse <= enable && edgeIn && terminal;
        end
    end

    property p_reload;
        @(posedge clk) disable iff (!rstN)
        (enable && edgeIn && terminal) |=> (count_r == $past(divValue) && pulse);
    endproperty
    a_reload: assert property (p_reload) else $error("divider did not reload");

    property p_noIdlePulse;
        @(posedge clk) disable iff (!rstN)
        !(enable && edgeIn) |=> !pulse;
    endproperty
    a_noIdlePulse: assert property (p_noIdlePulse) else $error("pulse without edge");
endmodule

//--- hdl/integer_n_clock_pll_control.sv
// digital control of the integer-n clock synthesizer: registers, dividers, detector, pump
// Notes on behaviour
// - feedback path divides vco directly, no prescaler
// - reference 14 bits, feedback 13 bits wide
// - locked output equals ref times n over r
// - dividers accept inputs up to 26 mhz
// - pump current is code plus one steps
// - fast acquire divisor sets pump boost timing
// - fast acquire enable raises pump current automatically
// - synth sleep bit disables the synthesizer
// - oscillator bias has four settings, two bits
// - reset values ff, zero, 38, zero
// - divisor divides reference to form period t
// - pulse over k periods gives k+1, max eight
// - boost only raises; code zero floor twice
// - divided reference compared with divided vco
`include "pll_cfg.svh"
module integer_n_clock_pll_control (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`ADDR_W-1:0] regAddr,
    input wire pll_pkg::byte_type regWrData,
    input wire logic regWrEn,
    output pll_pkg::byte_type regRdData,
    input wire logic refIn,
    input wire logic vcoIn,
    output logic pumpUp,
    output logic pumpDown,
    output logic [`LEVEL_W-1:0] pumpLevel,
    output logic [1:0] oscBias,
    output logic synthEnable,
    output logic oscEnable
);
    import pll_pkg::*;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rstMeta_r;
    logic rstN;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_r <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstN <= rstMeta_r;
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    byte_type standby_r;
    logic [1:0] oscBias_r;
    logic [5:0] refHigh_r;
    byte_type refLow_r;
    logic [4:0] fbHigh_r;
    byte_type fbLow_r;
    logic fastEn_r;
    logic [2:0] pumpCode_r;
    logic [3:0] faHigh_r;
    byte_type faLow_r;
    byte_type rdMux;

    wire wrStandby = regWrEn && (regAddr == `ADDR_STANDBY);
    wire wrBias = regWrEn && (regAddr == `ADDR_OSC_BIAS);
    wire wrPump = regWrEn && (regAddr == `ADDR_PUMP_CTRL);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            standby_r <= `RST_STANDBY;
            oscBias_r <= `RST_OSC_BIAS;
            refHigh_r <= `RST_REF_HIGH;
            refLow_r <= `RST_REF_LOW;
            fbHigh_r <= `RST_FB_HIGH;
            fbLow_r <= `RST_FB_LOW;
            fastEn_r <= 1'b0;
            pumpCode_r <= `RST_PUMP_CODE;
            faHigh_r <= `RST_FA_HIGH;
            faLow_r <= `RST_FA_LOW;
        end else if (regWrEn) begin
            unique case (regAddr)
                `ADDR_STANDBY: standby_r <= regWrData;
                `ADDR_OSC_BIAS: oscBias_r <= regWrData[`OSC_BIAS_MSB:`OSC_BIAS_LSB];
                `ADDR_REF_HIGH: refHigh_r <= regWrData[5:0];
                `ADDR_REF_LOW: refLow_r <= regWrData;
                `ADDR_FB_HIGH: fbHigh_r <= regWrData[4:0];
                `ADDR_FB_LOW: fbLow_r <= regWrData;
                `ADDR_PUMP_CTRL: begin
                    fastEn_r <= regWrData[`FAST_EN_BIT];
                    pumpCode_r <= regWrData[`PUMP_CODE_MSB:`PUMP_CODE_LSB];
                end
                `ADDR_FA_HIGH: faHigh_r <= regWrData[3:0];
                `ADDR_FA_LOW: faLow_r <= regWrData;
                default: ;
            endcase
        end
    end

    // unmapped addresses read zero
    assign rdMux =
        (regAddr == `ADDR_STANDBY) ? standby_r :
        (regAddr == `ADDR_OSC_BIAS) ? {4'h0, oscBias_r, 2'h0} :
        (regAddr == `ADDR_REF_HIGH) ? {2'h0, refHigh_r} :
        (regAddr == `ADDR_REF_LOW) ? refLow_r :
        (regAddr == `ADDR_FB_HIGH) ? {3'h0, fbHigh_r} :
        (regAddr == `ADDR_FB_LOW) ? fbLow_r :
        (regAddr == `ADDR_PUMP_CTRL) ? {1'b0, fastEn_r, 1'b0, pumpCode_r, 2'h0} :
        (regAddr == `ADDR_FA_HIGH) ? {4'h0, faHigh_r} :
        (regAddr == `ADDR_FA_LOW) ? faLow_r : 8'h00;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= rdMux;
        end
    end

    // ----------------------------------------
    // standby and oscillator controls
    // ----------------------------------------
    wire synthOn = !standby_r[`SYNTH_SLEEP_BIT];
    assign synthEnable = synthOn;
    assign oscEnable = !standby_r[`OSC_SLEEP_BIT];
    assign oscBias = oscBias_r;

    // ----------------------------------------
    // dividers
    // ----------------------------------------
    logic refPrev_r;
    logic vcoPrev_r;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            refPrev_r <= 1'b0;
            vcoPrev_r <= 1'b0;
        end else begin
            refPrev_r <= refIn;
            vcoPrev_r <= vcoIn;
        end
    end
    // one edge per two clocks at most, so 26 mhz inputs need a faster clk
    wire refRise = refIn && !refPrev_r;
    wire vcoRise = vcoIn && !vcoPrev_r;

    wire [`REF_DIV_W-1:0] refDivValue = {refHigh_r, refLow_r};
    wire [`FB_DIV_W-1:0] fbDivValue = {fbHigh_r, fbLow_r};
    wire [`FA_DIV_W-1:0] faDivValue = {faHigh_r, faLow_r};
    logic refPulse;
    logic fbPulse;
    logic faTick;

    edge_divider #(.WIDTH(`REF_DIV_W)) refDivider (
        .clk(clk), .rstN(rstN), .enable(synthOn), .edgeIn(refRise),
        .divValue(refDivValue), .pulse(refPulse)
    );
    // vco edges go straight into the n divider
    edge_divider #(.WIDTH(`FB_DIV_W)) fbDivider (
        .clk(clk), .rstN(rstN), .enable(synthOn), .edgeIn(vcoRise),
        .divValue(fbDivValue), .pulse(fbPulse)
    );
    edge_divider #(.WIDTH(`FA_DIV_W)) faDivider (
        .clk(clk), .rstN(rstN), .enable(synthOn), .edgeIn(refRise),
        .divValue(faDivValue), .pulse(faTick)
    );

    // ----------------------------------------
    // phase/frequency detector
    // ----------------------------------------
    pfd_state_type pfdState_r;
    pfd_state_type pfdState_nxt;
    // locking drives fb rate to ref rate, giving f_out = f_ref * n / r
    always_comb begin
        pfdState_nxt = pfdState_r;
        unique case (pfdState_r)
            PFD_IDLE: begin
                if (refPulse && !fbPulse) pfdState_nxt = PFD_UP;
                else if (fbPulse && !refPulse) pfdState_nxt = PFD_DOWN;
            end
            PFD_UP: if (fbPulse) pfdState_nxt = PFD_IDLE;
            PFD_DOWN: if (refPulse) pfdState_nxt = PFD_IDLE;
        endcase
        if (!synthOn) pfdState_nxt = PFD_IDLE;
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) pfdState_r <= PFD_IDLE;
        else pfdState_r <= pfdState_nxt;
    end
    assign pumpUp = (pfdState_r == PFD_UP);
    assign pumpDown = (pfdState_r == PFD_DOWN);

    // ----------------------------------------
    // charge pump level and fast acquire
    // ----------------------------------------
    logic [`LEVEL_W-1:0] widthCnt_r;
    logic [`LEVEL_W-1:0] boost_r;
    logic [`LEVEL_W-1:0] level_nxt;
    wire pfdActive = pumpUp || pumpDown;
    wire pfdEnd = pfdActive && (pfdState_nxt == PFD_IDLE);
    wire [`LEVEL_W-1:0] nominal = {1'b0, pumpCode_r} + `LEVEL_W'(1);
    wire [`LEVEL_W-1:0] widthLevel = (widthCnt_r >= `LEVEL_MAX - `LEVEL_W'(1)) ?
                                     `LEVEL_MAX : widthCnt_r + `LEVEL_W'(1);
    wire [`LEVEL_W-1:0] faLevel = (boost_r > `LEVEL_FA_FLOOR) ? boost_r : `LEVEL_FA_FLOOR;
    assign level_nxt = (fastEn_r && faLevel > nominal) ? faLevel : nominal;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            widthCnt_r <= '0;
            boost_r <= `LEVEL_W'(1);
            pumpLevel <= `LEVEL_W'(1);
        end else begin
            if (pfdEnd) widthCnt_r <= '0;
            else if (pfdActive && faTick && widthCnt_r != `LEVEL_MAX) widthCnt_r <= widthCnt_r + `LEVEL_W'(1);
            if (pfdEnd) boost_r <= widthLevel;
            pumpLevel <= level_nxt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_resetValues;
        @(posedge clk) $rose(rstN) |-> (standby_r == `RST_STANDBY && refLow_r == `RST_REF_LOW
            && refHigh_r == `RST_REF_HIGH && fbHigh_r == `RST_FB_HIGH);
    endproperty
    a_resetValues: assert property (p_resetValues) else $error("bad reset values");

    property p_sleepQuiet;
        @(posedge clk) disable iff (!rstN)
        !synthOn |=> !(pumpUp || pumpDown);
    endproperty
    a_sleepQuiet: assert property (p_sleepQuiet) else $error("pump active in standby");

    property p_upCause;
        @(posedge clk) disable iff (!rstN)
        $rose(pumpUp) |-> $past(refPulse) && !$past(fbPulse);
    endproperty
    a_upCause: assert property (p_upCause) else $error("up without reference pulse");

    property p_nominal;
        @(posedge clk) disable iff (!rstN)
        (!fastEn_r && $stable(pumpCode_r)) |=> pumpLevel == {1'b0, $past(pumpCode_r)} + 4'h1;
    endproperty
    a_nominal: assert property (p_nominal) else $error("pump level not code plus one");

    property p_floor;
        @(posedge clk) disable iff (!rstN)
        (fastEn_r && pumpCode_r == 3'h0) |=> pumpLevel >= `LEVEL_FA_FLOOR;
    endproperty
    a_floor: assert property (p_floor) else $error("fast acquire floor missed");

    property p_cap;
        @(posedge clk) disable iff (!rstN)
        pumpLevel <= `LEVEL_MAX && pumpLevel != 4'h0;
    endproperty
    a_cap: assert property (p_cap) else $error("pump level out of range");

    property p_boost;
        @(posedge clk) disable iff (!rstN)
        (pfdEnd && widthCnt_r == 4'h2) |=> boost_r == 4'h3;
    endproperty
    a_boost: assert property (p_boost) else $error("boost not width plus one");

    property p_biasWrite;
        @(posedge clk) disable iff (!rstN)
        wrBias |=> oscBias == $past(regWrData[`OSC_BIAS_MSB:`OSC_BIAS_LSB]);
    endproperty
    a_biasWrite: assert property (p_biasWrite) else $error("bias field not written");

    property p_oscSleep;
        @(posedge clk) disable iff (!rstN)
        (wrStandby && regWrData[`OSC_SLEEP_BIT]) |=> !oscEnable;
    endproperty
    a_oscSleep: assert property (p_oscSleep) else $error("oscillator not put to sleep");

    property p_pumpWrite;
        @(posedge clk) disable iff (!rstN)
        (wrPump && !regWrData[`FAST_EN_BIT]) |=> ##1 pumpLevel ==
            {1'b0, $past(regWrData[`PUMP_CODE_MSB:`PUMP_CODE_LSB], 2)} + 4'h1;
    endproperty
    a_pumpWrite: assert property (p_pumpWrite) else $error("code write not applied");
endmodule

//--- tb/edge_source_model.sv
// far-side source: bursts of one-cycle edges for the reference or vco input
module edge_source_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [15:0] count,
    output logic edgeOut = 1'b0,
    output logic busy = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_r = 16'h0000;
    logic [1:0] phase_r = 2'h0;
    // one high cycle then three low cycles, so edges never touch
    always @(posedge clk) begin
        if (start && !busy) begin
            left_r <= count;
            phase_r <= 2'h0;
            busy <= (count != 16'h0000);
        end else if (busy) begin
            phase_r <= phase_r + 2'h1;
            edgeOut <= (phase_r == 2'h0);
            if (phase_r == 2'h3) begin
                left_r <= left_r - 16'h0001;
                busy <= (left_r != 16'h0001);
            end
        end else begin
            edgeOut <= 1'b0;
        end
    end
endmodule

//--- tb/integer_n_clock_pll_control_tb.sv
// self-checking bench for the clock synthesizer control
`include "pll_cfg.svh"
module integer_n_clock_pll_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [`ADDR_W-1:0] regAddr = 4'h0;
    pll_pkg::byte_type regWrData = 8'h00;
    logic regWrEn = 1'b0;
    pll_pkg::byte_type regRdData;
    logic refIn, vcoIn, pumpUp, pumpDown, synthEnable, oscEnable;
    logic [`LEVEL_W-1:0] pumpLevel;
    logic [1:0] oscBias;
    logic refStart = 1'b0;
    logic vcoStart = 1'b0;
    logic refBusy, vcoBusy;
    logic [15:0] burstLen = 16'h0000;
    int miscompares = 0;
    int cmp_count = 0;
    integer_n_clock_pll_control integer_n_clock_pll_control_i (.clk(clk), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
        .refIn(refIn), .vcoIn(vcoIn), .pumpUp(pumpUp), .pumpDown(pumpDown),
        .pumpLevel(pumpLevel), .oscBias(oscBias), .synthEnable(synthEnable),
        .oscEnable(oscEnable));
    edge_source_model edge_source_model_i (.clk(clk), .start(refStart), .count(burstLen),
        .edgeOut(refIn), .busy(refBusy));
    edge_source_model edge_source_model_vco_i (.clk(clk), .start(vcoStart),
        .count(burstLen), .edgeOut(vcoIn), .busy(vcoBusy));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic writeReg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    task automatic readCheck(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        repeat (2) @(posedge clk);
        #1;
        check(name, exp, regRdData);
    endtask
    // sends n edges from one source, then lets the detector settle
    task automatic burst(input bit fromVco, input int n);
        int guard;
        @(posedge clk);
        burstLen <= 16'(n);
        if (fromVco) vcoStart <= 1'b1;
        else refStart <= 1'b1;
        @(posedge clk);
        vcoStart <= 1'b0;
        refStart <= 1'b0;
        guard = 0;
        do begin
            @(posedge clk);
            guard++;
        end while ((refBusy || vcoBusy) && guard < 5000);
        if (guard >= 5000) check("burst done", 8'h00, 8'h01);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic resetValues();
        readCheck("standby", `ADDR_STANDBY, 8'hFF);
        readCheck("ref high", `ADDR_REF_HIGH, 8'h00);
        readCheck("ref low", `ADDR_REF_LOW, 8'h38);
        readCheck("fb high", `ADDR_FB_HIGH, 8'h00);
        readCheck("bias", `ADDR_OSC_BIAS, 8'h00);
        readCheck("fb low", `ADDR_FB_LOW, 8'h3C);
        readCheck("fa low", `ADDR_FA_LOW, 8'h04);
        readCheck("pump ctrl", `ADDR_PUMP_CTRL, 8'h00);
        readCheck("unmapped", 4'h9, 8'h00);
        check("synthEnable", 8'h00, {7'h00, synthEnable});
        check("oscEnable", 8'h00, {7'h00, oscEnable});
        check("pumpLevel", 8'h01, {4'h0, pumpLevel});
    endtask
    task automatic biasAndStandby();
        for (int i = 0; i < 4; i++) begin
            writeReg(`ADDR_OSC_BIAS, 8'(i << 2) | 8'hF3);
            readCheck("bias", `ADDR_OSC_BIAS, 8'(i << 2));
            check("oscBias", 8'(i), {6'h00, oscBias});
        end
        writeReg(`ADDR_STANDBY, 8'hFB);
        readCheck("standby", `ADDR_STANDBY, 8'hFB);
        check("synthEnable", 8'h01, {7'h00, synthEnable});
        check("oscEnable", 8'h00, {7'h00, oscEnable});
    endtask
    task automatic pumpCodes();
        for (int c = 0; c < 8; c++) begin
            writeReg(`ADDR_PUMP_CTRL, 8'(c << 2));
            readCheck("pump ctrl", `ADDR_PUMP_CTRL, 8'(c << 2));
            check("pumpLevel", 8'(c + 1), {4'h0, pumpLevel});
        end
    endtask
    task automatic dividers();
        // counters load new divide values at once only while asleep, otherwise at the next terminal count
        writeReg(`ADDR_STANDBY, 8'hFF);
        writeReg(`ADDR_REF_HIGH, 8'hFF);
        readCheck("ref high", `ADDR_REF_HIGH, 8'h3F);
        writeReg(`ADDR_REF_HIGH, 8'h00);
        writeReg(`ADDR_REF_LOW, 8'h04);
        writeReg(`ADDR_FB_HIGH, 8'h01);
        writeReg(`ADDR_FB_LOW, 8'h05);
        readCheck("fb low", `ADDR_FB_LOW, 8'h05);
        writeReg(`ADDR_STANDBY, 8'hFB);
        burst(1'b0, 3);
        check("up early", 8'h00, {7'h00, pumpUp});
        burst(1'b0, 1);
        check("up", 8'h01, {7'h00, pumpUp});
        burst(1'b1, 260);
        check("up held", 8'h01, {7'h00, pumpUp});
        burst(1'b1, 1);
        check("up end", 8'h00, {7'h00, pumpUp});
        check("down idle", 8'h00, {7'h00, pumpDown});
        burst(1'b1, 261);
        check("down", 8'h01, {7'h00, pumpDown});
        burst(1'b0, 4);
        check("down end", 8'h00, {7'h00, pumpDown});
    endtask
    task automatic sleepAndFast();
        writeReg(`ADDR_STANDBY, 8'hFF);
        burst(1'b0, 4);
        check("sleep up", 8'h00, {7'h00, pumpUp});
        check("sleep down", 8'h00, {7'h00, pumpDown});
        writeReg(`ADDR_REF_LOW, 8'h01);
        writeReg(`ADDR_FB_HIGH, 8'h00);
        writeReg(`ADDR_FB_LOW, 8'h01);
        writeReg(`ADDR_FA_HIGH, 8'hFF);
        readCheck("fa high", `ADDR_FA_HIGH, 8'h0F);
        writeReg(`ADDR_FA_HIGH, 8'h00);
        writeReg(`ADDR_FA_LOW, 8'h01);
        writeReg(`ADDR_STANDBY, 8'hFB);
        writeReg(`ADDR_PUMP_CTRL, 8'h40);
        readCheck("pump ctrl", `ADDR_PUMP_CTRL, 8'h40);
        repeat (3) @(posedge clk);
        #1;
        check("floor", 8'h02, {4'h0, pumpLevel});
        burst(1'b0, 12);
        burst(1'b1, 1);
        check("boost", 8'h08, {4'h0, pumpLevel});
        // two periods wide gives three times the minimum
        burst(1'b0, 3);
        burst(1'b1, 1);
        check("boost three", 8'h03, {4'h0, pumpLevel});
        writeReg(`ADDR_PUMP_CTRL, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        check("no boost", 8'h01, {4'h0, pumpLevel});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        resetValues();
        biasAndStandby();
        pumpCodes();
        dividers();
        sleepAndFast();
        results();
    end
    // tests need about 3000 cycles; give up after about 10000
    initial begin
        #200us;
        miscompares++;
        results();
    end
endmodule
